// [verilog/bscr_system_control.v]
`timescale 1ns/1ps
`default_nettype none
`include "bscr_defs.vh"
module bscr_system_control (
	input wire core_clk,
	input wire rst,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire cfg_func,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	input wire [1:0] power_write,
	input wire [1:0] card_access,
	input wire [1:0] power_up_start,
	input wire [1:0] power_down_start,
	input wire [1:0] stream_done,
	input wire [1:0] delay_done,
	input wire [1:0] probe_active,
	input wire [1:0] card_is_32bit,
	input wire [1:0] card_is_16bit,
	input wire irq_a_in,
	input wire irq_b_in,
	input wire switch_clk_in,
	output wire irq_a_out,
	output wire irq_b_out,
	output wire interrupt_pin_tie_status,
	output wire [1:0] interrupt_slot_stepping,
	output wire switch_clk_out,
	output wire switch_clk_oe,
	output wire switch_clk,
	output wire irq2_out,
	output wire [1:0] card_change_irq,
	output wire [1:0] reserved_pin_oe,
	output wire [1:0] reserved_pin_out,
	output wire [1:0] supply_protect_on,
	output wire [1:0] addr_hi_float,
	output wire read_burst_down,
	output wire read_burst_up,
	output wire low_power_enable,
	output wire id_write_lock
);
	reg [1:0] step;
	reg tie;
	reg clk_src;
	reg route;
	reg irq_en;
	reg burst_dn;
	reg burst_up;
	reg low_pwr;
	reg id_lock;
	reg [3:0] g_rsv;
	reg [1:0] stream_busy;
	reg [1:0] rise_busy;
	reg [1:0] fall_busy;
	reg [1:0] up_dir;
	reg [15:0] div_cnt;
	reg div_clk;
	wire hit;
	wire wr_hit;
	wire wr_glob;
	wire [1:0] f_wr;
	wire [1:0] f_rd;
	wire [1:0] pw_flag;
	wire [1:0] act;
	wire [1:0] sup;
	wire [1:0] rvid;
	wire [1:0] rpd;
	wire [7:0] rsv_s;
	wire sel;
	assign hit = cfg_addr == `BSCR_OFFSET;
	assign wr_hit = cfg_wr && hit;
	assign wr_glob = wr_hit && !cfg_func;
	assign f_wr = {wr_hit && cfg_func, wr_hit && !cfg_func};
	assign f_rd = {cfg_rd && hit && cfg_func, cfg_rd && hit && !cfg_func};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : sock
			// one copy per function
			bscr_socket_bits u_bits (
				.core_clk(core_clk),
				.rst(rst),
				.wr_sel(f_wr[gi]),
				.rd_sel(f_rd[gi]),
				.be(cfg_be),
				.wdata(cfg_wdata),
				.power_write(power_write[gi]),
				.irq_enable(irq_en),
				.card_access(card_access[gi]),
				.power_write_irq_flag(pw_flag[gi]),
				.socket_activity(act[gi]),
				.supply_protection(sup[gi]),
				.reduced_video_port(rvid[gi]),
				.reserved_pin_drive(rpd[gi]),
				.rsv_bits(rsv_s[gi*4+3:gi*4])
			);
		end
	endgenerate
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			step <= 2'b00;
			tie <= 1'b0;
			clk_src <= 1'b0;
			route <= 1'b0;
			irq_en <= 1'b0;
			burst_dn <= 1'b1;
			burst_up <= 1'b0;
			low_pwr <= 1'b1;
			id_lock <= 1'b1;
			g_rsv <= 4'h0;
		end
		else if (wr_glob)
		begin
			if (cfg_be[3])
			begin
				step <= cfg_wdata[`BSCR_BIT_STEP_HI:`BSCR_BIT_STEP_LO];
				tie <= cfg_wdata[`BSCR_BIT_TIE];
				clk_src <= cfg_wdata[`BSCR_BIT_CLKSRC];
				route <= cfg_wdata[`BSCR_BIT_ROUTE];
				irq_en <= cfg_wdata[`BSCR_BIT_PWEN];
			end
			if (cfg_be[1])
			begin
				burst_dn <= cfg_wdata[`BSCR_BIT_BURSTDN];
				burst_up <= cfg_wdata[`BSCR_BIT_BURSTUP];
			end
			if (cfg_be[0])
			begin
				low_pwr <= cfg_wdata[`BSCR_BIT_LOWPWR];
				id_lock <= cfg_wdata[`BSCR_BIT_IDLOCK];
				g_rsv <= cfg_wdata[4:1];
			end
		end
	end
	// power stream and delay status per socket
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			stream_busy <= 2'b00;
			rise_busy <= 2'b00;
			fall_busy <= 2'b00;
			up_dir <= 2'b00;
		end
		else
		begin
			// direction of the stream in flight
			up_dir <= power_up_start | (up_dir & ~power_down_start);
			stream_busy <= (stream_busy | power_up_start | power_down_start)
				& ~(delay_done & ~(power_up_start | power_down_start));
			rise_busy <= (rise_busy & ~delay_done)
				| (stream_done & (power_up_start | (up_dir & ~power_down_start)));
			fall_busy <= (fall_busy & ~delay_done)
				| (stream_done & (power_down_start | (~up_dir & ~power_up_start)));
		end
	end
	// switch clock divider from core clock
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			div_cnt <= 16'h0000;
			div_clk <= 1'b0;
		end
		else if (div_cnt == `BSCR_SWCLK_DIV - 16'd1)
		begin
			div_cnt <= 16'h0000;
			div_clk <= ~div_clk;
		end
		else
			div_cnt <= div_cnt + 16'd1;
	end
	assign switch_clk_out = div_clk;
	assign switch_clk_oe = clk_src;
	assign switch_clk = clk_src ? div_clk : switch_clk_in;
	assign interrupt_slot_stepping = step;
	assign irq_a_out = irq_a_in | (tie & irq_b_in);
	assign irq_b_out = tie ? 1'b0 : irq_b_in;
	assign interrupt_pin_tie_status = tie;
	assign irq2_out = !route && |pw_flag;
	assign card_change_irq = route ? pw_flag : 2'b00;
	assign reserved_pin_oe = rpd & card_is_32bit;
	assign reserved_pin_out = 2'b00;
	assign supply_protect_on = ~sup & card_is_16bit;
	assign addr_hi_float = rvid & card_is_16bit;
	assign read_burst_down = burst_dn;
	assign read_burst_up = burst_up;
	assign low_power_enable = low_pwr;
	assign id_write_lock = id_lock;
	assign sel = cfg_func;
	always @(posedge core_clk)
	begin
		if (rst)
			cfg_rdata <= 32'h00000000;
		else if (cfg_rd && hit)
			cfg_rdata <= {step, tie,
				1'b0,
				clk_src, route, pw_flag[sel], irq_en,
				1'b0, rpd[sel], sup[sel], rvid[sel], rsv_s[sel*4 +: 4],
				burst_dn, burst_up, act[sel],
				1'b1,
				stream_busy[sel], rise_busy[sel], fall_busy[sel],
				probe_active[sel],
				1'b0,
				low_pwr, id_lock, g_rsv, 1'b0};
		else
			cfg_rdata <= 32'h00000000;
	end
endmodule // bscr_system_control
`default_nettype wire

// [verilog/bscr_defs.vh]
`ifndef BSCR_DEFS_VH
`define BSCR_DEFS_VH
`define BSCR_OFFSET 8'h80
`define BSCR_RESET 32'h00449060
`define BSCR_BIT_STEP_HI 31
`define BSCR_BIT_STEP_LO 30
`define BSCR_BIT_TIE 29
`define BSCR_BIT_RSVD28 28
`define BSCR_BIT_CLKSRC 27
`define BSCR_BIT_ROUTE 26
`define BSCR_BIT_PWFLAG 25
`define BSCR_BIT_PWEN 24
`define BSCR_BIT_RSVD23 23
`define BSCR_BIT_RPDRIVE 22
`define BSCR_BIT_SUPPLY 21
`define BSCR_BIT_RVIDEO 20
`define BSCR_BIT_RSV_HI 19
`define BSCR_BIT_RSV_LO 16
`define BSCR_BIT_BURSTDN 15
`define BSCR_BIT_BURSTUP 14
`define BSCR_BIT_ACT 13
`define BSCR_BIT_RSVD12 12
`define BSCR_BIT_STREAM 11
`define BSCR_BIT_RISE 10
`define BSCR_BIT_FALL 9
`define BSCR_BIT_PROBE 8
`define BSCR_BIT_RSVD7 7
`define BSCR_BIT_LOWPWR 6
`define BSCR_BIT_IDLOCK 5
`define BSCR_SWCLK_DIV 16'd4
`endif

// [verilog/bscr_socket_bits.v]
`timescale 1ns/1ps
`default_nettype none
`include "bscr_defs.vh"
module bscr_socket_bits (
	input wire core_clk,
	input wire rst,
	input wire wr_sel,
	input wire rd_sel,
	input wire [3:0] be,
	input wire [31:0] wdata,
	input wire power_write,
	input wire irq_enable,
	input wire card_access,
	output reg power_write_irq_flag,
	output reg socket_activity,
	output reg supply_protection,
	output reg reduced_video_port,
	output reg reserved_pin_drive,
	output reg [3:0] rsv_bits
);
	wire clr_flag;
	wire clr_act;
	assign clr_flag = wr_sel && be[3] && wdata[`BSCR_BIT_PWFLAG];
	assign clr_act = rd_sel && be[1];
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			power_write_irq_flag <= 1'b0;
			socket_activity <= 1'b0;
			supply_protection <= 1'b0;
			reduced_video_port <= 1'b0;
			reserved_pin_drive <= 1'b1;
			rsv_bits <= 4'h4;
		end
		else
		begin
			// set wins over clear
			if (power_write && irq_enable)
				power_write_irq_flag <= 1'b1;
			else if (clr_flag)
				power_write_irq_flag <= 1'b0;
			if (card_access)
				socket_activity <= 1'b1;
			else if (clr_act)
				socket_activity <= 1'b0;
			if (wr_sel && be[2])
			begin
				reserved_pin_drive <= wdata[`BSCR_BIT_RPDRIVE];
				supply_protection <= wdata[`BSCR_BIT_SUPPLY];
				reduced_video_port <= wdata[`BSCR_BIT_RVIDEO];
				rsv_bits <= wdata[`BSCR_BIT_RSV_HI:`BSCR_BIT_RSV_LO];
			end
		end
	end
endmodule // bscr_socket_bits
`default_nettype wire

// [verification/bscr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module bscr_host (
	input wire logic core_clk,
	input wire logic [31:0] cfg_rdata,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic cfg_func,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata
);
	initial {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
	// one-cycle strobe; read data taken while it stands; write data inverted once released
	task acc(input w, input f, input [7:0] a, input [3:0] b, input [31:0] d, output [31:0] r);
		@(negedge core_clk);
		{cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_be, cfg_wdata} = {w, !w, f, a, b, d};
		@(negedge core_clk);
		r = cfg_rdata;
		{cfg_wr, cfg_rd, cfg_wdata} = {2'b00, ~d};
	endtask
endmodule // bscr_host
`default_nettype wire

// [verification/bscr_system_control_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module bscr_system_control_chk (
	input wire logic core_clk, rst, cfg_rd, cfg_wr, cfg_func, irq_a_in, irq_b_in, irq_a_out,
	input wire logic interrupt_pin_tie_status, switch_clk_in, switch_clk_out, switch_clk_oe,
	input wire logic switch_clk, irq2_out,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_rdata,
	input wire logic [1:0] power_write, card_access, card_is_32bit, card_is_16bit,
	input wire logic [1:0] card_change_irq, reserved_pin_oe, reserved_pin_out, addr_hi_float
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_rd;
		cfg_rd && cfg_addr == 8'h80;
	endsequence
	sequence s_act;
		card_access[0] ##1 (!card_access[0] && !cfg_rd)
			##1 (cfg_rd && cfg_addr == 8'h80 && !cfg_func && cfg_be[1]);
	endsequence
	property p_rsvd; s_rd |=> cfg_rdata[12] && !cfg_rdata[28] && !cfg_rdata[7]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("fixed bits wrong");
	property p_act; s_act |=> cfg_rdata[13]; endproperty
	a_act: assert property (p_act) else $error("activity lost");
	property p_tie; interrupt_pin_tie_status |-> irq_a_out == (irq_a_in | irq_b_in); endproperty
	a_tie: assert property (p_tie) else $error("tie wrong");
	property p_clk; switch_clk == (switch_clk_oe ? switch_clk_out : switch_clk_in); endproperty
	a_clk: assert property (p_clk) else $error("switch clock wrong");
	property p_route; |card_change_irq |-> !irq2_out; endproperty
	a_route: assert property (p_route) else $error("both routes");
	property p_flag; $rose(card_change_irq[0]) && !$past(cfg_wr) |-> $past(power_write[0]); endproperty
	a_flag: assert property (p_flag) else $error("flag without write");
	property p_pin; reserved_pin_oe[0] |-> card_is_32bit[0] && !reserved_pin_out[0]; endproperty
	a_pin: assert property (p_pin) else $error("pin drive wrong");
	property p_float; addr_hi_float[0] |-> card_is_16bit[0]; endproperty
	a_float: assert property (p_float) else $error("float wrong");
endmodule // bscr_system_control_chk
bind bscr_system_control bscr_system_control_chk i_chk (.*);
`default_nettype wire

// [verification/bscr_system_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bscr_system_control_bench;
	logic core_clk = 0, rst = 1, irq_a_in = 0, irq_b_in = 0, switch_clk_in = 0;
	logic [1:0] power_write = 0, card_access = 0, power_up_start = 0, power_down_start = 0;
	logic [1:0] stream_done = 0, delay_done = 0, probe_active = 0, card_is_32bit = 0;
	logic [1:0] card_is_16bit = 0;
	logic cfg_wr, cfg_rd, cfg_func;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, q;
	wire [31:0] cfg_rdata;
	wire irq_a_out, irq_b_out, interrupt_pin_tie_status, switch_clk_out, switch_clk_oe, switch_clk;
	wire irq2_out, read_burst_down, read_burst_up, low_power_enable, id_write_lock;
	wire [1:0] interrupt_slot_stepping, card_change_irq, reserved_pin_oe, reserved_pin_out;
	wire [1:0] supply_protect_on, addr_hi_float;
	int n_errors = 0, n_tests = 0, t = 1, cyc = 0;
	bscr_system_control i_bscr_system_control (.*);
	bscr_host i_bscr_host (.*);
	initial forever #4 core_clk = ~core_clk;
	always #13 switch_clk_in = ~switch_clk_in;
	task chk(input string s, input [31:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input f, input [3:0] b, input [31:0] d);
		i_bscr_host.acc(1, f, 8'h80, b, d, q);
	endtask
	task rd(input f, input [7:0] a);
		i_bscr_host.acc(0, f, a, 4'hf, 0, q);
	endtask
	task nxt;
		$display("test %0d done", t++);
	endtask
	task end_sim;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk)
		if (++cyc == 3000)
		begin
			n_errors++;
			end_sim;
		end
	initial
	begin
		repeat (16) @(negedge core_clk);
		rst = 0;
		rd(0, 8'h80);
		chk("f0", q, 32'h00449060);
		rd(1, 8'h80);
		chk("f1", q, 32'h00449060);
		rd(0, 8'h84);
		chk("unmapped", q, 0);
		nxt;
		irq_b_in = 1;
		wr(0, 4'hf, 32'hf9444080);
		rd(0, 8'h80);
		chk("f0", q, 32'he9445000);
		chk("tie", irq_a_out, 1);
		chk("tieb", {interrupt_pin_tie_status, irq_b_out}, 2'b10);
		chk("lvl", {interrupt_slot_stepping, read_burst_down, read_burst_up, low_power_enable,
			id_write_lock, switch_clk_oe}, 7'b1101001);
		wr(1, 4'hf, 32'h00040000);
		rd(1, 8'h80);
		chk("f1", q, 32'he9045000);
		rd(0, 8'h80);
		chk("f0", q, 32'he9445000);
		card_is_32bit = 2'b11;
		#1 chk("pin", reserved_pin_oe, 2'b01);
		nxt;
		@(negedge core_clk) power_write = 2'b01;
		@(negedge core_clk) power_write = 0;
		chk("irq2", irq2_out, 1);
		wr(0, 4'h8, 32'hed000000);
		chk("csc", {card_change_irq, irq2_out}, 3'b010);
		wr(0, 4'h8, 32'hef000000);
		chk("csc", card_change_irq, 0);
		@(negedge core_clk) power_write = 2'b01;
		@(negedge core_clk) power_write = 0;
		chk("csc", card_change_irq, 2'b01);
		nxt;
		@(negedge core_clk) card_access = 2'b01;
		@(negedge core_clk) card_access = 0;
		rd(0, 8'h80);
		chk("act", q[13], 1);
		rd(0, 8'h80);
		chk("act", q[13], 0);
		probe_active = 2'b10;
		rd(1, 8'h80);
		chk("probe", q[8], 1);
		for (int k = 0; k < 2; k++)
		begin
			@(negedge core_clk) {power_down_start, power_up_start} = k ? 4'h4 : 4'h1;
			@(negedge core_clk) {power_down_start, power_up_start} = 0;
			rd(0, 8'h80);
			chk("strm", q[11:8], 4'h8);
			@(negedge core_clk) stream_done = 2'b01;
			@(negedge core_clk) stream_done = 0;
			rd(0, 8'h80);
			chk("strm", q[11:8], k ? 4'ha : 4'hc);
			@(negedge core_clk) delay_done = 2'b01;
			@(negedge core_clk) delay_done = 0;
			rd(0, 8'h80);
			chk("strm", q[11:8], 0);
		end
		nxt;
		card_is_16bit = 2'b01;
		wr(0, 4'h4, 32'h00740000);
		chk("float", addr_hi_float, 2'b01);
		chk("prot", supply_protect_on[0], 0);
		nxt;
		end_sim;
	end
endmodule // bscr_system_control_bench
`default_nettype wire
